// ==== bench/ebls_bus_model.sv ====
// Far-side memory word on the four-lane external system bus
module ebls_bus_model
  import ebls_pkg::*;
#(
  parameter logic [31:0] INIT_WORD = 32'h0405_0607
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wr_en_i,
  input  wire logic        st_valid_i,
  input  wire logic [3:0]  st_byte_en_i,
  input  wire logic [31:0] st_bus_data_i,
  output      logic [31:0] bus_word_o
);
  logic [31:0] mem_q;

  // Lane k written only under its own enable; no byte moves lanes
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      mem_q <= INIT_WORD;
    else if (wr_en_i && st_valid_i)
      for (int k = 0; k < 4; k++)
        if (st_byte_en_i[k])
          mem_q[8*k +: 8] <= st_bus_data_i[8*k +: 8];
  end

  // Word always offered; load path picks its lanes
  assign bus_word_o = mem_q;
endmodule

// ==== bench/endian_byte_lane_steering_bench.sv ====
module endian_byte_lane_steering_bench
  import ebls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic le; logic [1:0] sz, a; logic [31:0] d, eb; logic [3:0] be; logic [31:0] ld;} ebls_row_t;
  logic        clk = 0, rst = 1, le = 0, sv = 0, lv = 0, wr = 0, svo, lvo;
  logic [1:0]  sz = 0, a = 0;
  logic [31:0] sd = 0, bus, sbd, lrd;
  logic [3:0]  sbe;
  int          err_count = 0, num_checks = 0;
  // Memory word holds 04050607; byte stores replicate on every lane
  ebls_row_t rows [12] = '{
    '{1'h1, 2'h2, 2'h0, 32'h0102_0304, 32'h0102_0304, 4'hF, 32'h0405_0607},
    '{1'h0, 2'h2, 2'h0, 32'h0102_0304, 32'h0403_0201, 4'hF, 32'h0706_0504},
    '{1'h1, 2'h1, 2'h0, 32'h0000_0304, 32'h0304_0304, 4'h3, 32'h0000_0607},
    '{1'h1, 2'h1, 2'h2, 32'h0000_0304, 32'h0304_0304, 4'hC, 32'h0000_0405},
    '{1'h0, 2'h1, 2'h0, 32'h0000_0304, 32'h0403_0403, 4'h3, 32'h0000_0706},
    '{1'h0, 2'h1, 2'h2, 32'h0000_0304, 32'h0403_0403, 4'hC, 32'h0000_0504},
    '{1'h1, 2'h0, 2'h1, 32'h0000_0004, 32'h0404_0404, 4'h2, 32'h0000_0006},
    '{1'h1, 2'h0, 2'h3, 32'h0000_0004, 32'h0404_0404, 4'h8, 32'h0000_0004},
    '{1'h0, 2'h0, 2'h0, 32'h0000_0004, 32'h0404_0404, 4'h1, 32'h0000_0007},
    '{1'h0, 2'h0, 2'h2, 32'h0000_0004, 32'h0404_0404, 4'h4, 32'h0000_0005},
    '{1'h1, 2'h0, 2'h0, 32'h0000_0004, 32'h0404_0404, 4'h1, 32'h0000_0007},
    '{1'h1, 2'h3, 2'h1, 32'h0102_0304, 32'h0000_0000, 4'h0, 32'h0000_0000}};

  // Clock of 5 ns period
  always #2.5 clk = ~clk;

  ebls_top dut (.sys_clk_i(clk), .sys_rst_i(rst), .endian_select_bit_i(le), .st_valid_i(sv), .st_size_i(sz),
    .st_addr_i(a), .st_reg_data_i(sd), .ld_valid_i(lv), .ld_size_i(sz), .ld_addr_i(a), .ld_bus_data_i(bus),
    .st_valid_o(svo), .st_bus_data_o(sbd), .st_byte_en_o(sbe), .ld_valid_o(lvo), .ld_reg_data_o(lrd));
  ebls_bus_model mem (.sys_clk_i(clk), .sys_rst_i(rst), .wr_en_i(wr), .st_valid_i(svo), .st_byte_en_i(sbe),
    .st_bus_data_i(sbd), .bus_word_o(bus));

  task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("ERROR %0t exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic check_bits(input logic [3:0] exp, input logic [3:0] act);
    check_word({28'h0, exp}, {28'h0, act});
  endtask

  // Store and load issued together, results one cycle later
  task automatic run_row(input ebls_row_t r);
    @(posedge clk);
    le <= r.le; sv <= 1; lv <= 1; sz <= r.sz; a <= r.a; sd <= r.d;
    @(posedge clk);
    sv <= 0; lv <= 0;
    @(negedge clk);
    check_bits(4'h3, {2'h0, svo, lvo});
    check_word(r.eb, sbd);
    check_bits(r.be, sbe);
    check_word(r.ld, lrd);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the few dozen cycles needed
  initial
  begin
    #5000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    check_bits(4'h0, sbe);
    check_bits(4'h0, {2'h0, svo, lvo});
    check_word(32'h0, sbd | lrd);
    @(posedge clk) rst <= 0;
    foreach (rows[i])
      run_row(rows[i]);
    // Idle cycle after the last row must clear every lane
    @(negedge clk);
    check_bits(4'h0, sbe);
    check_bits(4'h0, {2'h0, svo, lvo});
    check_word(32'h0, sbd | lrd);
    // Back-to-back byte loads, one result per cycle
    @(posedge clk);
    le <= 1; lv <= 1; sz <= 2'h0; a <= 2'h1;
    @(posedge clk);
    a <= 2'h2;
    @(negedge clk);
    check_word(32'h0000_0006, lrd);
    @(posedge clk);
    lv <= 0;
    @(negedge clk);
    check_word(32'h0000_0005, lrd);
    @(posedge clk);
    wr <= 1;
    // Round trip through memory in big-endian mode
    run_row('{1'h0, 2'h2, 2'h0, 32'h0405_0607, 32'h0706_0504, 4'hF, 32'h0706_0504});
    run_row('{1'h0, 2'h0, 2'h0, 32'h0000_0004, 32'h0404_0404, 4'h1, 32'h0000_0004});
    run_row('{1'h0, 2'h2, 2'h0, 32'h0000_0000, 32'h0, 4'hF, 32'h0405_0607});
    // Reset in mid-run overrides a pending request
    @(posedge clk);
    rst <= 1; sv <= 1; lv <= 1;
    @(posedge clk);
    @(negedge clk);
    check_bits(4'h0, sbe);
    check_bits(4'h0, {2'h0, svo, lvo});
    check_word(32'h0, sbd | lrd);
    @(posedge clk);
    rst <= 0; sv <= 0; lv <= 0;
    run_row(rows[0]);
    complete_run();
  end
endmodule

// ==== src/ebls_pkg.sv ====
package ebls_pkg;

  // ---------------------------------------------------------------
  // Bus lane layout
  // ---------------------------------------------------------------
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned LANE_NUM   = 4;
  localparam int unsigned WORD_W     = 32;
  localparam logic [1:0]  LANE0      = 2'h0;
  localparam logic [1:0]  LANE2      = 2'h2;

  // ---------------------------------------------------------------
  // Mode and size encodings
  // ---------------------------------------------------------------
  localparam logic        ENDIAN_LITTLE = 1'h1;
  localparam logic        ENDIAN_BIG    = 1'h0;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;
  localparam logic [3:0]  BE_NONE       = 4'h0;

  typedef enum logic [1:0]
  {
    EBLS_SZ_BYTE = 2'b00,
    EBLS_SZ_HALF = 2'b01,
    EBLS_SZ_WORD = 2'b10
  } ebls_size_t;

endpackage

// ==== src/ebls_swap.sv ====
// Reverses the byte order of a word; bits within each byte are untouched
module ebls_swap
  import ebls_pkg::*;
(
  input  wire logic [31:0] word_i,
  output      logic [31:0] word_o
);

  // ---------------------------------------------------------------
  // Byte reversal
  // ---------------------------------------------------------------
  // Whole bytes only, never a bit mirror
  always_comb
  begin
    for (int i = 0; i < LANE_NUM; i++)
    begin
      word_o[i*LANE_W +: LANE_W] = word_i[(LANE_NUM-1-i)*LANE_W +: LANE_W]; // RQ6
    end
  end

endmodule

// ==== src/ebls_top.sv ====
// Functional notes
// RQ1: Bus lanes are bytes: lane3 31:24, lane2 23:16, lane1 15:8, lane0 7:0.
// RQ2: Byte at word offset k always rides lane k in either mode.
// RQ3: The external system bus side is always little-endian ordered.
// RQ4: Big-endian: base address selects most significant byte of a word.
// RQ5: Little-endian: base address selects least significant byte of a word.
// RQ6: Endian conversion reverses bytes in a word, never bits.
// RQ7: Little-endian word access passes register value to lanes unchanged.
// RQ8: Little-endian half at offset 2 uses lanes 3,2; offset 0 lanes 1,0.
// RQ9: Little-endian byte lands on lane equal to the two low address bits.
// RQ10: Endian select bit one means little-endian, zero means big-endian.
// RQ11: Big-endian word access reverses byte order between register and bus.
// RQ12: Big-endian half swaps its two bytes inside the addressed lane pair.
// RQ13: Loads apply the inverse mapping, returning data in low register bits.
module ebls_top
  import ebls_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        endian_select_bit_i,
  input  wire logic        st_valid_i,
  input  wire logic [1:0]  st_size_i,
  input  wire logic [1:0]  st_addr_i,
  input  wire logic [31:0] st_reg_data_i,
  input  wire logic        ld_valid_i,
  input  wire logic [1:0]  ld_size_i,
  input  wire logic [1:0]  ld_addr_i,
  input  wire logic [31:0] ld_bus_data_i,
  output      logic        st_valid_o,
  output      logic [31:0] st_bus_data_o,
  output      logic [3:0]  st_byte_en_o,
  output      logic        ld_valid_o,
  output      logic [31:0] ld_reg_data_o
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Lane enables for a size and offset; misaligned halves keep pair
  function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] m;
    m = BE_NONE;
    case (sz)
      EBLS_SZ_BYTE: m = 4'h1 << a;                         // RQ2
      EBLS_SZ_HALF: m = a[1] ? 4'hC : 4'h3;               // RQ8
      EBLS_SZ_WORD: m = 4'hF;
      default:      m = BE_NONE;
    endcase
    return m;
  endfunction

  // Swap the two low bytes of a halfword
  function automatic logic [15:0] half_swap(input logic [15:0] h);
    return {h[7:0], h[15:8]};
  endfunction

  // ---------------------------------------------------------------
  // Word reversal for full-word big-endian traffic
  // ---------------------------------------------------------------
  logic [31:0] st_rev;
  logic [31:0] ld_rev;

  ebls_swap u_st_swap // RQ6
  (
    .word_i (st_reg_data_i),
    .word_o (st_rev)
  );

  ebls_swap u_ld_swap // RQ6
  (
    .word_i (ld_bus_data_i),
    .word_o (ld_rev)
  );

  // ---------------------------------------------------------------
  // Store lane steering
  // ---------------------------------------------------------------
  logic        little_st;
  logic [15:0] st_half;
  logic [31:0] st_bus_d;

  assign little_st = (endian_select_bit_i == ENDIAN_LITTLE); // RQ10
  // Bytes within a half are reversed only in big-endian mode
  assign st_half   = little_st ? st_reg_data_i[15:0] : half_swap(st_reg_data_i[15:0]); // RQ12

  // Lane placement; offsets never move, only byte order does
  always_comb
  begin
    st_bus_d = WORD_RST;
    case (st_size_i)
      EBLS_SZ_BYTE: st_bus_d = {4{st_reg_data_i[7:0]}};                      // RQ9
      EBLS_SZ_HALF: st_bus_d = {st_half, st_half};                           // RQ8
      EBLS_SZ_WORD: st_bus_d = little_st ? st_reg_data_i : st_rev;           // RQ7 RQ11
      default:      st_bus_d = WORD_RST;
    endcase
  end

  // Registered store outputs; bus side is always little-endian lanes
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_valid_o    <= 1'b0;
      st_bus_data_o <= WORD_RST;
      st_byte_en_o  <= BE_NONE;
    end
    else
    begin
      st_valid_o    <= st_valid_i;
      st_bus_data_o <= st_valid_i ? st_bus_d : WORD_RST;                     // RQ3
      st_byte_en_o  <= st_valid_i ? lane_mask(st_size_i, st_addr_i) : BE_NONE; // RQ1
    end
  end

  // ---------------------------------------------------------------
  // Load lane extraction
  // ---------------------------------------------------------------
  logic        little_ld;
  logic [7:0]  ld_byte;
  logic [15:0] ld_half;
  logic [31:0] ld_reg_d;

  assign little_ld = (endian_select_bit_i == ENDIAN_LITTLE); // RQ10
  assign ld_byte   = ld_bus_data_i[ld_addr_i*LANE_W +: LANE_W];               // RQ2
  assign ld_half   = ld_addr_i[1] ? ld_bus_data_i[31:16] : ld_bus_data_i[15:0];

  // Inverse of store steering; unused upper bits read zero
  always_comb
  begin
    ld_reg_d = WORD_RST;
    case (ld_size_i)
      EBLS_SZ_BYTE: ld_reg_d = {24'h000000, ld_byte};                        // RQ13 RQ4 RQ5
      EBLS_SZ_HALF: ld_reg_d = {16'h0000, little_ld ? ld_half : half_swap(ld_half)}; // RQ13
      EBLS_SZ_WORD: ld_reg_d = little_ld ? ld_bus_data_i : ld_rev;           // RQ13
      default:      ld_reg_d = WORD_RST;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ld_valid_o    <= 1'b0;
      ld_reg_data_o <= WORD_RST;
    end
    else
    begin
      ld_valid_o    <= ld_valid_i;
      ld_reg_data_o <= ld_valid_i ? ld_reg_d : WORD_RST;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Store path, plus three load checks: lane data per size and mode
  le_word_pass_a: assert property (st_valid_i && st_size_i == EBLS_SZ_WORD && endian_select_bit_i |=> // RQ7
    st_bus_data_o == $past(st_reg_data_i)) else $error("LE word store altered");
  be_word_rev_a: assert property (st_valid_i && st_size_i == EBLS_SZ_WORD && !endian_select_bit_i |=> // RQ11
    st_bus_data_o == {$past(st_reg_data_i[7:0]), $past(st_reg_data_i[15:8]),
    $past(st_reg_data_i[23:16]), $past(st_reg_data_i[31:24])}) else $error("BE word not reversed");
  byte_lane_a: assert property (st_valid_i && st_size_i == EBLS_SZ_BYTE |=> // RQ2
    st_byte_en_o == (4'h1 << $past(st_addr_i))) else $error("Byte lane wrong");
  byte_data_a: assert property (st_valid_i && st_size_i == EBLS_SZ_BYTE |=> // RQ9
    st_bus_data_o[$past(st_addr_i)*8 +: 8] == $past(st_reg_data_i[7:0])) else $error("Byte data wrong");
  le_half_a: assert property (st_valid_i && st_size_i == EBLS_SZ_HALF && endian_select_bit_i && st_addr_i[1] |=> // RQ8
    st_byte_en_o == 4'hC && st_bus_data_o[31:16] == $past(st_reg_data_i[15:0])) else $error("LE half wrong");
  be_half_a: assert property (st_valid_i && st_size_i == EBLS_SZ_HALF && !endian_select_bit_i && // RQ12
    st_addr_i[1] |=> st_bus_data_o[31:16] == {$past(st_reg_data_i[7:0]), $past(st_reg_data_i[15:8]) })
    else $error("BE half wrong");
  be_ld_byte_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_BYTE && !endian_select_bit_i && // RQ4
    ld_addr_i == LANE0 |=> ld_reg_data_o == {24'h000000, $past(ld_bus_data_i[7:0])})
    else $error("BE byte load wrong");
  le_ld_word_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_WORD && endian_select_bit_i |=> // RQ13
    ld_reg_data_o == $past(ld_bus_data_i)) else $error("LE word load wrong");
  be_ld_half_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_HALF && !endian_select_bit_i && // RQ12
    ld_addr_i == LANE2 |=> ld_reg_data_o == {16'h0000, $past(ld_bus_data_i[23:16]), $past(ld_bus_data_i[31:24])})
    else $error("BE half load");
  idle_quiet_a: assert property (!st_valid_i |=> st_byte_en_o == BE_NONE && !st_valid_o) // RQ1
    else $error("Idle lanes on");
  // Full word lights all four lanes
  word_lanes_a: assert property (st_valid_i && st_size_i == EBLS_SZ_WORD |=> st_byte_en_o == 4'hF) // RQ1
    else $error("Word lanes wrong");
  // Little-endian lower half keeps its byte order on lanes one and zero
  le_half_low_a: assert property (st_valid_i && st_size_i == EBLS_SZ_HALF && endian_select_bit_i && // RQ8
    !st_addr_i[1] |=> st_byte_en_o == 4'h3 && st_bus_data_o[15:0] == $past(st_reg_data_i[15:0]))
    else $error("LE low half wrong");
  // Unused size code must not drive any lane, or memory would be corrupted
  bad_size_a: assert property (st_valid_i && !(st_size_i inside {EBLS_SZ_BYTE, EBLS_SZ_HALF, EBLS_SZ_WORD}) |=> // RQ1
    st_byte_en_o == BE_NONE && st_bus_data_o == WORD_RST)
    else $error("Bad size drove lanes");
  // Every accepted store answers exactly one cycle later
  st_answer_a: assert property (st_valid_i |=> st_valid_o) // RQ3
    else $error("Store answer missing");

  // ---------------------------------------------------------------
  // Load path checks
  // ---------------------------------------------------------------
  // Little-endian byte at the base reads the least significant lane
  le_ld_byte_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_BYTE && endian_select_bit_i && // RQ5
    ld_addr_i == LANE0 |=> ld_reg_data_o == {24'h000000, $past(ld_bus_data_i[7:0])})
    else $error("LE byte load wrong");
  // Byte loads take lane two for offset two in either mode
  ld_byte_lane_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_BYTE && ld_addr_i == LANE2 |=> // RQ2
    ld_reg_data_o == {24'h000000, $past(ld_bus_data_i[23:16])})
    else $error("Byte load lane wrong");
  // Little-endian upper half returns unchanged from lanes three and two
  le_ld_half_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_HALF && endian_select_bit_i && // RQ8
    ld_addr_i == LANE2 |=> ld_reg_data_o == {16'h0000, $past(ld_bus_data_i[31:16])})
    else $error("LE half load wrong");
  // Big-endian word load is the byte-reversed bus word
  be_ld_word_a: assert property (ld_valid_i && ld_size_i == EBLS_SZ_WORD && !endian_select_bit_i |=> // RQ11
    ld_reg_data_o == {$past(ld_bus_data_i[7:0]), $past(ld_bus_data_i[15:8]),
    $past(ld_bus_data_i[23:16]), $past(ld_bus_data_i[31:24])})
    else $error("BE word load wrong");
  // Every accepted load answers exactly one cycle later
  ld_answer_a: assert property (ld_valid_i |=> ld_valid_o) // RQ13
    else $error("Load answer missing");
  // Without a load the result reads zero, so stale data never leaks
  ld_idle_zero_a: assert property (!ld_valid_i |=> !ld_valid_o && ld_reg_data_o == WORD_RST) // RQ13
    else $error("Idle load not zero");

  // Main scenarios
  be_word_c: cover property (st_valid_i && st_size_i == EBLS_SZ_WORD && !endian_select_bit_i);
  le_half_c: cover property (st_valid_i && st_size_i == EBLS_SZ_HALF && endian_select_bit_i);
  ld_byte_c: cover property (ld_valid_i && ld_size_i == EBLS_SZ_BYTE ##1 ld_valid_i);
  be_ld_half_c: cover property (ld_valid_i && ld_size_i == EBLS_SZ_HALF && !endian_select_bit_i);
  bad_size_c: cover property (st_valid_i && !(st_size_i inside {EBLS_SZ_BYTE, EBLS_SZ_HALF, EBLS_SZ_WORD}));

endmodule
